// ==== twc_pkg.sv ====
// constants shared by both ends of the two-wire configuration link
`default_nettype none

package twc_pkg;

  // ************************************************************
  // bus addressing
  // ************************************************************
  localparam logic [5:0] DEV_ADDR_HI = 6'h26;   // fixed upper bits 100110
  localparam logic [6:0] DEV_ADDR_SEL0 = 7'h4C; // address with select low
  localparam logic RW_READ = 1'b1;              // direction bit for read
  localparam int unsigned FILT_XTAL_PERIODS = 3; // scl deglitch length

  // ************************************************************
  // target register file
  // ************************************************************
  localparam logic [7:0] REG_XTAL_COMP = 8'h2B; // crystal_compensation
  localparam logic [7:0] XTAL_COMP_RST = 8'h00; // default after reset
  localparam logic [7:0] REG_RST = 8'h00;       // default of other regs
  // recommended compensation for full-speed operation
  localparam logic [7:0] XTAL_COMP_23M0 = 8'h18; // 23 to 23.9 MHz
  localparam logic [7:0] XTAL_COMP_23M9 = 8'h17; // up to 25 MHz
  localparam logic [7:0] XTAL_COMP_25M0 = 8'h16; // up to 26.2 MHz
  localparam logic [7:0] XTAL_COMP_26M2 = 8'h15; // up to 27 MHz

  // ************************************************************
  // host controller registers
  // ************************************************************
  localparam logic [3:0] HREG_CTRL = 4'h0;   // w: bit0 go, bit1 read
  localparam logic [3:0] HREG_TARGET = 4'h1; // 7-bit target address
  localparam logic [3:0] HREG_INDEX = 4'h2;  // register index
  localparam logic [3:0] HREG_WDATA = 4'h3;  // byte to write
  localparam logic [3:0] HREG_RDATA = 4'h4;  // byte read back
  localparam logic [3:0] HREG_STATUS = 4'h5; // bit0 busy, bit1 nack
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_RD = 1;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_NACK = 1;
  localparam int unsigned QTR_CYC_DEF = 25; // clk_sys per scl quarter

  // compensation value from rates in kHz
  function automatic logic [7:0] xtal_comp_calc(
    input int unsigned max_pixel_rate,
    input int unsigned reference_osc_freq
  );
    int unsigned v;
    v = 1 + (2 * max_pixel_rate) / reference_osc_freq;
    return v[7:0];
  endfunction : xtal_comp_calc

endpackage : twc_pkg

`default_nettype wire

// ==== twc_link_if.sv ====
// two-wire link between the host end and the target end
`default_nettype none

interface twc_link_if;
  logic scl;        // serial clock, host only
  logic tgt_sda_o;  // target data output level
  logic tgt_sda_oe; // target pulls data line
  logic hst_sda_o;  // host data output level
  logic hst_sda_oe; // host pulls data line
  logic sda;        // resolved data line, pulled up

  // open-drain wired-and with pull-up
  assign sda = !((tgt_sda_oe && !tgt_sda_o) || (hst_sda_oe && !hst_sda_o));

  modport target (input scl, input sda, output tgt_sda_o,
                  output tgt_sda_oe);
  modport host (output scl, input sda, output hst_sda_o,
                output hst_sda_oe);
endinterface : twc_link_if

`default_nettype wire

// ==== twc_target_end.sv ====
// target end: serial configuration port with register file
//
// Design decision made here: the strobed register port.
`default_nettype none

module twc_target_end
  import twc_pkg::*;
#(
  parameter int unsigned FILT_CYC = FILT_XTAL_PERIODS
)
(
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  // address select pin
  input wire logic addr_sel,
  // link
  twc_link_if.target link,
  // user side
  output logic [7:0] xtal_comp_q,
  output logic wr_stb_q,
  output logic [7:0] wr_addr_q,
  output logic [7:0] wr_data_q
);

  // ************************************************************
  // parameter check
  // ************************************************************
  if (FILT_CYC < 1 || FILT_CYC > 15)
  begin : g_bad_filt
    $error("FILT_CYC must lie in 1..15");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } twc_tst_t;

  localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);

  // ************************************************************
  // input synchronisers and scl filter
  // ************************************************************
  logic scl_m_q, scl_s_q;     // scl sync stages
  logic sda_m_q, sda_s_q;     // sda sync stages
  logic sda_p_q;              // sda one cycle back
  logic sel_m_q, sel_s_q;     // address select sync stages
  logic scl_f_q;              // filtered scl
  logic [3:0] filt_cnt_q;     // cycles scl has differed
  logic scl_rise_q, scl_fall_q; // filtered edge pulses

  // two flops on every pin
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      sel_m_q <= 1'b0;
      sel_s_q <= 1'b0;
    end
    else
    begin
      scl_m_q <= link.scl;
      scl_s_q <= scl_m_q;
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      sel_m_q <= addr_sel;
      sel_s_q <= sel_m_q;
    end
  end

  // deglitch: follow scl only after it held for FILT_CYC cycles
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_f_q <= 1'b1;
      filt_cnt_q <= 4'h0;
      scl_rise_q <= 1'b0;
      scl_fall_q <= 1'b0;
    end
    else
    begin
      scl_rise_q <= 1'b0;
      scl_fall_q <= 1'b0;
      if (scl_s_q == scl_f_q)
        filt_cnt_q <= 4'h0;
      else if (filt_cnt_q == FILT_LAST)
      begin
        scl_f_q <= scl_s_q;
        filt_cnt_q <= 4'h0;
        scl_rise_q <= scl_s_q;
        scl_fall_q <= !scl_s_q;
      end
      else
        filt_cnt_q <= filt_cnt_q + 4'h1;
    end
  end

  // ************************************************************
  // bus conditions
  // ************************************************************
  logic start_det; // data falls while clock high
  logic stop_det;  // data rises while clock high
  logic [6:0] own_addr;
  assign start_det = scl_f_q && sda_p_q && !sda_s_q;
  assign stop_det = scl_f_q && !sda_p_q && sda_s_q;
  assign own_addr = {DEV_ADDR_HI, sel_s_q};

  // ************************************************************
  // transfer state machine
  // ************************************************************
  twc_tst_t state_q;
  logic [2:0] bit_cnt_q;  // bits in the current byte
  logic full_q;           // eight bits received
  logic [7:0] shift_q;    // receive and transmit shifter
  logic [7:0] ptr_q;      // register pointer
  logic rw_q;             // transaction direction
  logic first_q;          // next written byte is the index
  logic sda_oe_q;         // pulling data low
  logic host_ack_q;       // host acknowledged read byte
  logic [7:0] mem_q [256]; // configuration registers
  logic [7:0] rd_byte;

  assign rd_byte = mem_q[ptr_q];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      full_q <= 1'b0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      sda_oe_q <= 1'b0;
      host_ack_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end
    else
    begin
      wr_stb_q <= 1'b0;
      if (start_det)
      begin
        // any start, repeated or not, opens a fresh address phase
        state_q <= ST_ADDR;
        bit_cnt_q <= 3'h0;
        full_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end
      else if (stop_det)
      begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          // ignore everything until a start
          ST_IDLE: sda_oe_q <= 1'b0;
          // shift in address or written bytes
          ST_ADDR, ST_WR:
          begin
            if (scl_rise_q)
            begin
              shift_q <= {shift_q[6:0], sda_s_q};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == 3'h7)
                full_q <= 1'b1;
            end
            if (scl_fall_q && full_q)
            begin
              full_q <= 1'b0;
              bit_cnt_q <= 3'h0;
              if (state_q == ST_ADDR)
              begin
                if (shift_q[7:1] == own_addr)
                begin
                  rw_q <= shift_q[0];
                  first_q <= 1'b1;
                  sda_oe_q <= 1'b1;
                  state_q <= ST_ADDR_ACK;
                end
                else
                  state_q <= ST_IDLE;
              end
              else
              begin
                sda_oe_q <= 1'b1;
                state_q <= ST_WR_ACK;
                if (first_q)
                begin
                  ptr_q <= shift_q;
                  first_q <= 1'b0;
                end
                else
                begin
                  wr_stb_q <= 1'b1;
                  wr_addr_q <= ptr_q;
                  wr_data_q <= shift_q;
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          // end of address acknowledge: pick direction
          ST_ADDR_ACK:
          begin
            if (scl_fall_q)
            begin
              bit_cnt_q <= 3'h0;
              if (rw_q == RW_READ)
              begin
                shift_q <= rd_byte;
                ptr_q <= ptr_q + 8'h01;
                sda_oe_q <= !rd_byte[7];
                state_q <= ST_RD;
              end
              else
              begin
                sda_oe_q <= 1'b0;
                state_q <= ST_WR;
              end
            end
          end
          // release after acknowledging a written byte
          ST_WR_ACK:
          begin
            if (scl_fall_q)
            begin
              sda_oe_q <= 1'b0;
              state_q <= ST_WR;
            end
          end
          // shift out read byte, one bit per filtered fall
          ST_RD:
          begin
            if (scl_fall_q)
            begin
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == 3'h7)
              begin
                sda_oe_q <= 1'b0;
                state_q <= ST_RD_ACK;
              end
              else
              begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe_q <= !shift_q[6];
              end
            end
          end
          // host acknowledges or ends the read
          ST_RD_ACK:
          begin
            if (scl_rise_q)
              host_ack_q <= !sda_s_q;
            if (scl_fall_q)
            begin
              bit_cnt_q <= 3'h0;
              if (host_ack_q)
              begin
                shift_q <= rd_byte;
                ptr_q <= ptr_q + 8'h01;
                sda_oe_q <= !rd_byte[7];
                state_q <= ST_RD;
              end
              else
                state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // register file, cleared by power-on or pin reset
  // ************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 256; i++)
        mem_q[i] <= REG_RST;
      mem_q[REG_XTAL_COMP] <= XTAL_COMP_RST;
      xtal_comp_q <= XTAL_COMP_RST;
    end
    else if (wr_stb_q)
    begin
      mem_q[wr_addr_q] <= wr_data_q;
      if (wr_addr_q == REG_XTAL_COMP)
        xtal_comp_q <= wr_data_q;
    end
  end

  // ************************************************************
  // link drive: open drain, never drives high
  // ************************************************************
  assign link.tgt_sda_o = 1'b0;
  assign link.tgt_sda_oe = sda_oe_q;

endmodule : twc_target_end

`default_nettype wire

// ==== twc_host_end.sv ====
// host end: two-wire controller driven through small registers
`default_nettype none

module twc_host_end
  import twc_pkg::*;
#(
  parameter int unsigned QTR_CYC = QTR_CYC_DEF
)
(
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata_q,
  // link
  twc_link_if.host link
);

  // ************************************************************
  // parameter check
  // ************************************************************
  if (QTR_CYC < 8 || QTR_CYC > 65535)
  begin : g_bad_qtr
    $error("QTR_CYC must lie in 8..65535");
  end

  typedef enum logic [2:0] {
    HOP_START, HOP_TX, HOP_RX, HOP_STOP, HOP_DONE
  } twc_hop_t;

  localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);
  localparam logic [2:0] STEP_STOP_WR = 3'h4;
  localparam logic [2:0] STEP_STOP_RD = 3'h6;

  // ************************************************************
  // registers
  // ************************************************************
  logic [6:0] target_q;  // target bus address
  logic [7:0] index_q;   // register index
  logic [7:0] wdata_q;   // byte to write
  logic [7:0] rdata_q;   // byte read back
  logic busy_q, nack_q, read_q;
  logic go;

  assign go = cpu_wr && cpu_addr == HREG_CTRL && cpu_wdata[CTRL_GO] &&
              !busy_q;

  // software writes
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      target_q <= DEV_ADDR_SEL0;
      index_q <= 8'h00;
      wdata_q <= 8'h00;
    end
    else if (cpu_wr)
    begin
      case (cpu_addr)
        HREG_TARGET: target_q <= cpu_wdata[6:0];
        HREG_INDEX: index_q <= cpu_wdata;
        HREG_WDATA: wdata_q <= cpu_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cpu_rdata_q <= 8'h00;
    else if (cpu_rd)
    begin
      case (cpu_addr)
        HREG_TARGET: cpu_rdata_q <= {1'b0, target_q};
        HREG_INDEX: cpu_rdata_q <= index_q;
        HREG_WDATA: cpu_rdata_q <= wdata_q;
        HREG_RDATA: cpu_rdata_q <= rdata_q;
        HREG_STATUS: cpu_rdata_q <= {6'h00, nack_q, busy_q};
        default: cpu_rdata_q <= 8'h00;
      endcase
    end
    else
      cpu_rdata_q <= 8'h00;
  end

  // ************************************************************
  // operation list
  // ************************************************************
  logic [2:0] step_q;
  twc_hop_t op;
  logic [7:0] tx_byte;

  // write: start, addr+w, index, data, stop
  // read: start, addr+w, index, start, addr+r, byte, stop
  always_comb
  begin
    op = HOP_DONE;
    tx_byte = {target_q, 1'b0};
    case (step_q)
      3'h0: op = HOP_START;
      3'h1: op = HOP_TX;
      3'h2:
      begin
        op = HOP_TX;
        tx_byte = index_q;
      end
      3'h3:
      begin
        op = read_q ? HOP_START : HOP_TX;
        tx_byte = wdata_q;
      end
      3'h4:
      begin
        op = read_q ? HOP_TX : HOP_STOP;
        tx_byte = {target_q, RW_READ};
      end
      3'h5: op = read_q ? HOP_RX : HOP_DONE;
      3'h6: op = read_q ? HOP_STOP : HOP_DONE;
      default: op = HOP_DONE;
    endcase
  end

  // ************************************************************
  // bit engine: four quarters per bit
  // ************************************************************
  logic sda_m_q, sda_s_q; // data line sync stages
  logic [15:0] div_q;     // quarter divider
  logic [1:0] qtr_q;      // quarter within bit
  logic [3:0] bit_q;      // bit 0..7, 8 is acknowledge
  logic [7:0] rx_q;       // received bits
  logic scl_q, sda_oe_q;
  logic tick;

  assign tick = busy_q && div_q == QTR_LAST;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end
    else
    begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      read_q <= 1'b0;
      step_q <= 3'h0;
      div_q <= 16'h0000;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      rx_q <= 8'h00;
      rdata_q <= 8'h00;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end
    else if (go)
    begin
      busy_q <= 1'b1;
      nack_q <= 1'b0;
      read_q <= cpu_wdata[CTRL_RD];
      step_q <= 3'h0;
      div_q <= 16'h0000;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
    end
    else if (busy_q)
    begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      if (tick)
      begin
        qtr_q <= qtr_q + 2'h1;
        case (op)
          HOP_START:
          begin
            case (qtr_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_oe_q <= 1'b1;
              default:
              begin
                scl_q <= 1'b0;
                step_q <= step_q + 3'h1;
              end
            endcase
          end
          HOP_TX, HOP_RX:
          begin
            case (qtr_q)
              // data changes only while the clock is low
              2'h0: sda_oe_q <= op == HOP_TX && bit_q < 4'h8 &&
                               !tx_byte[3'(4'h7 - bit_q)];
              2'h1: scl_q <= 1'b1;
              2'h2: ;
              default:
              begin
                scl_q <= 1'b0;
                bit_q <= bit_q + 4'h1;
                if (bit_q < 4'h8)
                  rx_q <= {rx_q[6:0], sda_s_q};
                else
                begin
                  bit_q <= 4'h0;
                  step_q <= step_q + 3'h1;
                  if (op == HOP_RX)
                    rdata_q <= rx_q;
                  else if (sda_s_q)
                  begin
                    nack_q <= 1'b1;
                    step_q <= read_q ? STEP_STOP_RD : STEP_STOP_WR;
                  end
                end
              end
            endcase
          end
          HOP_STOP:
          begin
            case (qtr_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_oe_q <= 1'b0;
              default: busy_q <= 1'b0;
            endcase
          end
          default: busy_q <= 1'b0;
        endcase
      end
    end
  end

  // host alone drives the clock; data line open drain
  assign link.scl = scl_q;
  assign link.hst_sda_o = 1'b0;
  assign link.hst_sda_oe = sda_oe_q;

endmodule : twc_host_end

`default_nettype wire

// ==== twc_link_checker.sv ====
// link assertions for the two-wire configuration link
`default_nettype none

module twc_link_checker (
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe,
  input wire logic hst_sda_o,
  input wire logic hst_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // wire properties
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_od;
    !tgt_sda_o && !hst_sda_o;
  endproperty
  a_od: assert property (p_od)
    else $error("data line driven high");
  property p_tgt_chg;
    $changed(tgt_sda_oe) |-> !scl;
  endproperty
  a_tgt_chg: assert property (p_tgt_chg)
    else $error("target data changed with clock high");
  property p_launch;
    $rose(tgt_sda_oe) |-> !$past(scl, 4);
  endproperty
  a_launch: assert property (p_launch)
    else $error("target drove before filtered fall");
  property p_hold;
    $rose(tgt_sda_oe) |=> tgt_sda_oe [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("target acknowledge too short");
  property p_stop;
    scl && $rose(sda) |=> !tgt_sda_oe [*8];
  endproperty
  a_stop: assert property (p_stop)
    else $error("target drove after stop");
  property p_start;
    scl && $fell(sda) |=> !tgt_sda_oe [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("target drove after start");
  property p_hst;
    $rose(scl) |-> $stable(hst_sda_oe) [*8];
  endproperty
  a_hst: assert property (p_hst)
    else $error("host data changed with clock high");
  property p_scl_hi;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_hi: assert property (p_scl_hi)
    else $error("serial clock high phase too short");
endmodule : twc_link_checker

`default_nettype wire

// ==== two_wire_config_slave_tb.sv ====
// self-checking bench joining host end and target end
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin n_fail++; \
  $display("unexpected %s exp %0h seen %0h", nm, e, s); end end

module two_wire_config_slave_tb
  import twc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals and ends
  // ************************************************************
  localparam int unsigned QTR = 10; // shortened clock quarter
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic addr_sel = 1'b0;
  logic [3:0] cpu_addr = 4'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_rdata_q, xtal_comp_q, wr_addr_q, wr_data_q, s, d;
  logic wr_stb_q;
  logic [31:0] seed = 32'h0000936A; // 37738
  logic [7:0] comp [5];
  int n_fail = 0;
  int n_checks = 0;
  int n_stb = 0;
  twc_link_if link ();

  always #5 clk_sys = ~clk_sys;
  // count write strobes of the target
  always @(posedge clk_sys) if (wr_stb_q === 1'b1) n_stb++;

  twc_host_end #(.QTR_CYC(QTR)) twc_host_end_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata_q(cpu_rdata_q),
    .link(link));
  twc_target_end twc_target_end_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr_sel(addr_sel), .link(link), .xtal_comp_q(xtal_comp_q),
    .wr_stb_q(wr_stb_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q));
  twc_link_checker twc_link_checker_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .scl(link.scl), .sda(link.sda),
    .tgt_sda_o(link.tgt_sda_o), .tgt_sda_oe(link.tgt_sda_oe),
    .hst_sda_o(link.hst_sda_o), .hst_sda_oe(link.hst_sda_oe));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // expected bus address for a select level
  function automatic logic [6:0] own(input logic sel);
    return {DEV_ADDR_HI, sel};
  endfunction : own
  // compensation from pixel rate and crystal, same units
  function automatic logic [7:0] comp_of(input int r, input int f);
    return 8'(1 + (2 * r) / f);
  endfunction : comp_of
  task automatic cw(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= v;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask : cw
  task automatic cr(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    #1 v = cpu_rdata_q;
  endtask : cr
  // one link transfer, status returned once busy drops
  task automatic xfer(input logic [6:0] ta, input logic [7:0] idx,
    input logic [7:0] wd, input logic rd, output logic [7:0] st);
    int n;
    cw(HREG_TARGET, {1'b0, ta});
    cw(HREG_INDEX, idx);
    cw(HREG_WDATA, wd);
    cw(HREG_CTRL, {6'h00, rd, 1'b1});
    n = 0;
    st = 8'h01;
    while (st[STAT_BUSY] !== 1'b0 && n < 3000)
    begin
      cr(HREG_STATUS, st);
      n++;
    end
    if (n >= 3000) n_fail++;
  endtask : xfer
  // write then read back one register
  task automatic wr_rd(input logic [7:0] idx, input logic [7:0] v);
    int k;
    k = n_stb;
    xfer(own(addr_sel), idx, v, 1'b0, s);
    `CHK("wr_nack", 1'b0, s[STAT_NACK])
    `CHK("wr_stb", k + 1, n_stb)
    `CHK("wr_idx", idx, wr_addr_q)
    `CHK("wr_data", v, wr_data_q)
    xfer(own(addr_sel), idx, 8'h00, 1'b1, s);
    cr(HREG_RDATA, d);
    `CHK("rd_data", v, d)
  endtask : wr_rd
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    comp = '{XTAL_COMP_23M0, XTAL_COMP_23M9, XTAL_COMP_25M0,
      XTAL_COMP_26M2, comp_of(263, 24)};
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK("comp_rst", XTAL_COMP_RST, xtal_comp_q)
    `CHK("scl_idle", 1'b1, link.scl)
    `CHK("sda_idle", 1'b1, link.sda)
    cr(4'hF, d);
    `CHK("unmapped", 8'h00, d)
    xfer(own(1'b0), 8'h10, 8'h00, 1'b1, s);
    cr(HREG_RDATA, d);
    `CHK("reg_rst", REG_RST, d)
    // every compensation value, then read back
    foreach (comp[i])
    begin
      wr_rd(REG_XTAL_COMP, comp[i]);
      `CHK("comp", comp[i], xtal_comp_q)
    end
    // wrong address must be ignored
    xfer(own(1'b1), REG_XTAL_COMP, 8'h5A, 1'b0, s);
    `CHK("mis_nack", 1'b1, s[STAT_NACK])
    `CHK("mis_keep", comp[4], xtal_comp_q)
    // random registers, data and select level
    repeat (8)
    begin
      seed = xs(seed);
      @(posedge clk_sys);
      addr_sel <= seed[16];
      repeat (4) @(posedge clk_sys);
      wr_rd(seed[7:0], seed[15:8]);
      xfer(own(!addr_sel), seed[7:0], 8'h00, 1'b1, s);
      `CHK("sel_nack", 1'b1, s[STAT_NACK])
    end
    // reset pin in mid-run
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("pin_rst", XTAL_COMP_RST, xtal_comp_q)
    @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr_rd(REG_XTAL_COMP, XTAL_COMP_23M9);
    final_report();
  end

  // hang guard
  initial
  begin
    // about 44k cycles expected, so 80k leaves ample margin
    #800000;
    n_fail++;
    final_report();
  end
endmodule : two_wire_config_slave_tb

`undef CHK
`default_nettype wire
